// File: include/mpps_regs.svh
// Register map, field positions and reset values of the
// motor PWM protection and synchronisation block.
// Assumes a 32-bit register port with byte addresses.
`ifndef MPPS_REGS_SVH
`define MPPS_REGS_SVH
`define MPPS_OFS_CFG 8'h00
`define MPPS_OFS_STAT 8'h04
`define MPPS_OFS_CMP0 8'h08
`define MPPS_KEY 8'h5A
`define MPPS_KEY_HI 31
`define MPPS_KEY_LO 24
`define MPPS_EFLT_HI 23
`define MPPS_EFLT_LO 16
`define MPPS_OFLT_HI 15
`define MPPS_OFLT_LO 8
`define MPPS_CFG_EMGCMP 7
`define MPPS_CFG_EMGPIN 6
`define MPPS_CFG_CMPA 5
`define MPPS_CFG_PINA 2
`define MPPS_CFG_MASK 32'h00FFFFFF
`define MPPS_ST_EMERGENCY_LATCHED 9
`define MPPS_ST_EMG 8
`define MPPS_ST_OVERLOAD_LATCHED_ANY 7
`define MPPS_ST_CHL 6
`define MPPS_ST_OVL 3
`define MPPS_ST_CH 2
`define MPPS_C_IRQ 31
`define MPPS_C_SEL_HI 28
`define MPPS_C_SEL_LO 26
`define MPPS_C_EOC 25
`define MPPS_C_TRG 24
`define MPPS_C_BYP 23
`define MPPS_C_DIR 16
`define MPPS_C_MASK 32'h9F81FFFF
`define MPPS_SEL_LAST 3'h4
`define MPPS_RST_WORD 32'h00000000
`endif

// File: include/mpps_pkg.sv
// Types shared by the protection and synchronisation block.
// Assumes mpps_regs.svh holds the numeric constants.
package mpps_pkg;
  typedef logic [31:0] mpps_word_t;
  typedef logic [7:0] mpps_addr_t;
  typedef enum logic [1:0] {
    MPPS_ACT_HIZ = 2'h0,
    MPPS_ACT_LOW = 2'h1,
    MPPS_ACT_HIGH = 2'h2,
    MPPS_ACT_NONE = 2'h3
  } mpps_action_t;
endpackage

// File: hdl/mpps_filter.sv
// Pulse filter: output follows input only after the input has
// held its new level for len ticks of the filter time unit.
// Assumes tick is a one-cycle enable pulse on core_clk.
`timescale 1ns/1ns
`default_nettype none
module mpps_filter #(
  parameter int LEN_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [LEN_W-1:0] len,
  input wire logic din,
  output logic dout
);
  logic [LEN_W-1:0] count;
  wire differ = din != dout;
  wire lastTick = tick && (count + 1'b1 >= len);

  // Count stable ticks of a changed level, restart on any bounce
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      dout <= 1'b0;
    end else if (!differ) begin
      count <= '0;
    end else if (len == '0 || lastTick) begin
      dout <= din;
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/mpps_top.sv
// Protection and compare-synchronisation logic of the motor PWM unit.
// Assumes counter value, direction and update pulses come from the
// counter, and action/force settings from the channel registers.
`timescale 1ns/1ns
`default_nettype none
`include "mpps_regs.svh"
module mpps_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire mpps_pkg::mpps_addr_t regAddr,
  input wire mpps_pkg::mpps_word_t regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output mpps_pkg::mpps_word_t regRdata,
  input wire logic emergencyPin,
  input wire logic [2:0] faultPin,
  input wire logic [4:0] comparatorOutput,
  input wire logic [4:0] comparatorEmergencyEnable,
  input wire logic [7:0] faultFilterTimeUnit,
  input wire logic [15:0] pwmCounterValue,
  input wire logic counterDir,
  input wire logic atPeriod,
  input wire logic atZero,
  input wire logic shadowUpdatePoint,
  input wire logic [11:0] emergencyAction,
  input wire logic [11:0] overloadAction,
  input wire logic [5:0] forceEnable,
  input wire logic [5:0] forceHiZ,
  input wire logic [5:0] forceValue,
  input wire logic [5:0] pwmLevel,
  output logic [5:0] pwmOut,
  output logic [5:0] pwmOutEn,
  output logic emergencyActive,
  output logic [2:0] overloadActive,
  output logic protIrq,
  output logic cmpIrq,
  output logic adcStart,
  output logic [2:0] adcInput,
  output logic adcEocIrqEnable
);
  import mpps_pkg::*;

  ////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [8:0] syncMeta;
  logic [8:0] syncOut;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta <= '0;
      syncOut <= '0;
    end else begin
      syncMeta <= {comparatorOutput, faultPin, emergencyPin};
      syncOut <= syncMeta;
    end
  end
  wire emgPinS = syncOut[0];
  wire [2:0] faultPinS = syncOut[3:1];
  wire [4:0] cmpOutS = syncOut[8:4];

  ////////////////////////////////////////////////////////////
  // Register decode
  mpps_word_t cfg;
  mpps_word_t shadowCmp;
  mpps_word_t activeCmp;
  logic [4:0] latched;

  function automatic logic keyOk(input mpps_word_t w);
    keyOk = w[`MPPS_KEY_HI:`MPPS_KEY_LO] == `MPPS_KEY;
  endfunction

  wire selCfg = regAddr == `MPPS_OFS_CFG;
  wire selStat = regAddr == `MPPS_OFS_STAT;
  wire selCmp = regAddr == `MPPS_OFS_CMP0;
  wire wrCfg = regWrite && selCfg && keyOk(regWdata);
  wire wrStat = regWrite && selStat && keyOk(regWdata);
  wire wrCmp = regWrite && selCmp;
  wire wrBypass = wrCmp && regWdata[`MPPS_C_BYP];

  ////////////////////////////////////////////////////////////
  // Raw conditions
  wire emgCmpOn = cfg[`MPPS_CFG_EMGCMP];
  wire emgPinOn = cfg[`MPPS_CFG_EMGPIN];
  wire [2:0] chanCmpOn = cfg[`MPPS_CFG_CMPA -: 3];
  wire [2:0] chanPinOn = cfg[`MPPS_CFG_PINA -: 3];
  wire [7:0] emgLen = cfg[`MPPS_EFLT_HI:`MPPS_EFLT_LO];
  wire [7:0] ovlLen = cfg[`MPPS_OFLT_HI:`MPPS_OFLT_LO];
  // Channel bit 2 is A, so reverse to index A as 0
  wire [2:0] pinOnA0 = {chanPinOn[0], chanPinOn[1], chanPinOn[2]};
  wire [2:0] cmpOnA0 = {chanCmpOn[0], chanCmpOn[1], chanCmpOn[2]};
  wire emgRaw = (emgPinOn && emgPinS) ||
                (emgCmpOn && |(cmpOutS & comparatorEmergencyEnable));
  wire [2:0] ovlRaw = (pinOnA0 & faultPinS) | (cmpOnA0 & cmpOutS[2:0]);

  ////////////////////////////////////////////////////////////
  // Filter time unit divider
  logic [7:0] unitCnt;
  wire unitTick = unitCnt == 8'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unitCnt <= 8'h00;
    end else if (unitTick) begin
      unitCnt <= (faultFilterTimeUnit == 8'h00) ? 8'h00 : faultFilterTimeUnit - 8'h01;
    end else begin
      unitCnt <= unitCnt - 8'h01;
    end
  end

  // Pulse filters: index 0 emergency, 1 to 3 channels A to C
  logic [3:0] filt;
  wire [3:0] rawAll = {ovlRaw, emgRaw};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gFilt
      mpps_filter #(.LEN_W(8)) uFilt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tick(unitTick),
        .len(gi == 0 ? emgLen : ovlLen),
        .din(rawAll[gi]),
        .dout(filt[gi])
      );
    end
  endgenerate
  wire emgFilt = filt[0];
  wire [2:0] ovlFilt = filt[3:1];
  wire ovlAny = |ovlFilt;

  ////////////////////////////////////////////////////////////
  // Latched status: bit 4 emergency, 3 global, 2..0 chan A..C
  // Channel A goes to the top of the three, as in the status word
  wire [2:0] ovlAHigh = {ovlFilt[0], ovlFilt[1], ovlFilt[2]};
  wire [4:0] latchSet = {emgFilt, ovlAny, ovlAHigh};
  wire [4:0] wrLatch = {regWdata[`MPPS_ST_EMERGENCY_LATCHED], regWdata[`MPPS_ST_OVERLOAD_LATCHED_ANY],
                        regWdata[`MPPS_ST_CHL], regWdata[`MPPS_ST_CHL-1],
                        regWdata[`MPPS_ST_CHL-2]};
  wire [4:0] latchClr = wrStat ? ~wrLatch : 5'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 5'h00;
    end else begin
      latched <= (latched & ~latchClr) | latchSet;
    end
  end

  // Configuration register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `MPPS_RST_WORD;
    end else if (wrCfg) begin
      cfg <= regWdata & `MPPS_CFG_MASK;
    end
  end

  ////////////////////////////////////////////////////////////
  // Compare shadow and active copies
  wire updateNow = shadowUpdatePoint ? atZero : atPeriod;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadowCmp <= `MPPS_RST_WORD;
      activeCmp <= `MPPS_RST_WORD;
    end else begin
      if (wrCmp) begin
        shadowCmp <= regWdata & `MPPS_C_MASK;
      end
      if (wrBypass) begin
        activeCmp <= regWdata & `MPPS_C_MASK;
      end else if (updateNow) begin
        activeCmp <= shadowCmp;
      end
    end
  end

  // Match on value and direction, one event per equality
  wire matchNow = activeCmp[15:0] == pwmCounterValue &&
                  activeCmp[`MPPS_C_DIR] == counterDir;
  logic matchPrev;
  wire matchHit = matchNow && !matchPrev;
  wire [2:0] selCode = activeCmp[`MPPS_C_SEL_HI:`MPPS_C_SEL_LO];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      matchPrev <= 1'b0;
      cmpIrq <= 1'b0;
      adcStart <= 1'b0;
      adcInput <= 3'h0;
      adcEocIrqEnable <= 1'b0;
    end else begin
      matchPrev <= matchNow;
      cmpIrq <= matchHit && activeCmp[`MPPS_C_IRQ];
      adcStart <= matchHit && activeCmp[`MPPS_C_TRG];
      if (matchHit && activeCmp[`MPPS_C_TRG]) begin
        adcInput <= (selCode > `MPPS_SEL_LAST) ? `MPPS_SEL_LAST : selCode;
        adcEocIrqEnable <= activeCmp[`MPPS_C_EOC];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the strobe only
  wire [31:0] statWord = {22'h000000, latched[4], emgFilt, latched[3],
                          latched[2:0], ovlAny, ovlAHigh};
  wire [31:0] readMux = selCfg ? cfg :
                        selStat ? statWord :
                        selCmp ? shadowCmp : 32'h00000000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= `MPPS_RST_WORD;
    end else begin
      regRdata <= regRead ? readMux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////
  // Status forwarding and output override
  assign emergencyActive = emgFilt;
  assign overloadActive = ovlFilt;
  assign protIrq = |latched;

  // Resolve one output: enable and level, enable in the MSB
  function automatic logic [1:0] applyAct(input logic [1:0] act);
    case (act)
      MPPS_ACT_HIZ: applyAct = 2'h0;
      MPPS_ACT_LOW: applyAct = 2'h2;
      MPPS_ACT_HIGH: applyAct = 2'h3;
      default: applyAct = 2'h1;
    endcase
  endfunction

  // Combinational so protection acts without waiting for a period
  generate
    for (gi = 0; gi < 6; gi++) begin : gOut
      wire [1:0] eAct = emergencyAction[2*gi+1:2*gi];
      wire [1:0] oAct = overloadAction[2*gi+1:2*gi];
      wire useEmg = emgFilt && eAct != MPPS_ACT_NONE;
      wire useOvl = ovlFilt[gi/2] && oAct != MPPS_ACT_NONE;
      wire [1:0] eRes = applyAct(eAct);
      wire [1:0] oRes = applyAct(oAct);
      // Enable then level; priority emergency, overload, force
      wire [1:0] res = useEmg ? {eRes[1], eRes[0]} :
                       useOvl ? {oRes[1], oRes[0]} :
                       forceEnable[gi] ? {!forceHiZ[gi], forceValue[gi]} :
                       {1'b1, pwmLevel[gi]};
      assign pwmOutEn[gi] = res[1];
      assign pwmOut[gi] = res[1] & res[0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////
  // Assertions
  AST_CFG_KEY: assert property (@(posedge core_clk) disable iff (!rst_n)
    regWrite && selCfg && !keyOk(regWdata) |=> $stable(cfg))
    else $error("config changed on unkeyed write");

  AST_EMG_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    emgFilt |=> latched[4])
    else $error("emergency not latched");

  AST_CHAN_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovlFilt[0] |=> latched[2] && latched[3])
    else $error("channel A overload not latched");

  AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    latched[4] && !wrStat |=> latched[4])
    else $error("latched bit dropped without clear");

  AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    emgFilt || ovlAny |=> protIrq)
    else $error("protection interrupt missing");

  AST_LIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRead && selStat |=> regRdata[`MPPS_ST_EMG] == $past(emgFilt))
    else $error("live emergency bit wrong");

  AST_PRIO: assert property (@(posedge core_clk) disable iff (!rst_n)
    emgFilt && emergencyAction[3:2] == MPPS_ACT_LOW |-> pwmOutEn[1] && !pwmOut[1])
    else $error("emergency action not dominant");

  AST_CMP_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    matchHit && activeCmp[`MPPS_C_IRQ] |=> cmpIrq)
    else $error("compare interrupt missing");

  AST_ADC: assert property (@(posedge core_clk) disable iff (!rst_n)
    adcStart |-> $past(matchNow) && !$past(matchPrev))
    else $error("conversion start without match");

  AST_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmpIrq |-> $past(counterDir) == $past(activeCmp[`MPPS_C_DIR]))
    else $error("match with wrong direction");

  AST_BYPASS: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrBypass |=> activeCmp[15:0] == $past(regWdata[15:0]))
    else $error("bypass write not active");

  COV_EMG: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(emgFilt));
  COV_CLR: cover property (@(posedge core_clk) disable iff (!rst_n) wrStat ##1 !latched[3]);
  COV_ADC: cover property (@(posedge core_clk) disable iff (!rst_n) adcStart && cmpIrq);
  COV_UPD: cover property (@(posedge core_clk) disable iff (!rst_n) updateNow && !wrCmp);
endmodule
`default_nettype wire

// File: dv/mpps_far_model.sv
// Far-side model: PWM counter with period and zero pulses.
// Assumes the block's clock and reset; run low freezes the count.
`timescale 1ns/1ns
`default_nettype none
module mpps_far_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic [15:0] cnt,
  output logic dir,
  output logic atPeriod,
  output logic atZero
);
  // Counts 0 to 15; direction flips at each wrap, like an up-down count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      dir <= 1'b0;
    end else if (run) begin
      cnt <= cnt + 16'h0001;
      if (cnt == 16'h000F) begin
        cnt <= 16'h0000;
        dir <= ~dir;
      end
    end
  end
  // Update points stay quiet while frozen, so a shadow write cannot load
  assign atPeriod = run && (cnt == 16'h000F);
  assign atZero = run && (cnt == 16'h0000);
endmodule
`default_nettype wire

// File: dv/test_motor_pwm_protection_sync.sv
// Self-checking bench of the protection and compare block.
// Assumes mpps_pkg is compiled first and mpps_regs.svh is on the path.
`timescale 1ns/1ns
`default_nettype none
`include "mpps_regs.svh"
module test_motor_pwm_protection_sync;
  import mpps_pkg::*;
  logic core_clk, rst_n, regWrite, regRead, emergencyPin, counterDir, atPeriod, atZero;
  logic shadowUpdatePoint, emergencyActive, protIrq, cmpIrq, adcStart, adcEocIrqEnable, run;
  mpps_addr_t regAddr;
  mpps_word_t regWdata, regRdata, w;
  logic [2:0] faultPin, overloadActive, adcInput;
  logic [4:0] comparatorOutput, comparatorEmergencyEnable;
  logic [7:0] faultFilterTimeUnit;
  logic [15:0] pwmCounterValue;
  logic [11:0] emergencyAction, overloadAction;
  logic [5:0] forceEnable, forceHiZ, forceValue, pwmLevel, pwmOut, pwmOutEn;
  int err_count, compares;

  mpps_top mpps_top_inst (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .emergencyPin(emergencyPin), .faultPin(faultPin), .comparatorOutput(comparatorOutput),
    .comparatorEmergencyEnable(comparatorEmergencyEnable),
    .faultFilterTimeUnit(faultFilterTimeUnit), .pwmCounterValue(pwmCounterValue),
    .counterDir(counterDir), .atPeriod(atPeriod), .atZero(atZero),
    .shadowUpdatePoint(shadowUpdatePoint), .emergencyAction(emergencyAction),
    .overloadAction(overloadAction), .forceEnable(forceEnable), .forceHiZ(forceHiZ),
    .forceValue(forceValue), .pwmLevel(pwmLevel), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn),
    .emergencyActive(emergencyActive), .overloadActive(overloadActive), .protIrq(protIrq),
    .cmpIrq(cmpIrq), .adcStart(adcStart), .adcInput(adcInput),
    .adcEocIrqEnable(adcEocIrqEnable));
  mpps_far_model mpps_far_model_inst (.core_clk(core_clk), .rst_n(rst_n), .run(run),
    .cnt(pwmCounterValue), .dir(counterDir), .atPeriod(atPeriod), .atZero(atZero));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and waits
  task automatic check(input mpps_word_t got, input mpps_word_t exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input mpps_addr_t a, input mpps_word_t d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input mpps_addr_t a, input mpps_word_t e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(regRdata, e);
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic stop_test;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, write key and unmapped place
  task automatic t_regs;
    pwmLevel <= 6'h15;
    rdchk(`MPPS_OFS_CFG, 32'h0);
    check({pwmOut, pwmOutEn}, 12'h57F);
    rdchk(`MPPS_OFS_STAT, 32'h0);
    rdchk(8'h40, 32'h0);
    wr(`MPPS_OFS_CFG, 32'h11123456);
    rdchk(`MPPS_OFS_CFG, 32'h0);
    wr(`MPPS_OFS_CFG, 32'h5A123456);
    rdchk(`MPPS_OFS_CFG, 32'h00123456);
    wr(8'h40, 32'h5A00FFFF);
    rdchk(`MPPS_OFS_CMP0, 32'h0);
    wr(`MPPS_OFS_CFG, 32'h5A000000);
  endtask
  // Short pulses dropped, long ones pass, both filters
  task automatic t_filter;
    int n;
    faultFilterTimeUnit <= 8'h02;
    wr(`MPPS_OFS_CFG, 32'h5A040444);
    emergencyPin <= 1'b1;
    faultPin <= 3'h1;
    idle(3);
    emergencyPin <= 1'b0;
    faultPin <= 3'h0;
    repeat (20) begin
      @(posedge core_clk);
      check({emergencyActive, overloadActive}, 4'h0);
    end
    emergencyPin <= 1'b1;
    faultPin <= 3'h1;
    n = 0;
    while (emergencyActive !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    idle(3);
    check({emergencyActive, overloadActive}, 4'h9);
    check(n >= 6, 1'b1);
    rdchk(`MPPS_OFS_STAT, 32'h3CC);
    emergencyPin <= 1'b0;
    faultPin <= 3'h0;
    idle(40);
    wr(`MPPS_OFS_STAT, 32'h5A000000);
  endtask
  // Overload and emergency override priority, status, clearing
  task automatic t_prot;
    faultFilterTimeUnit <= 8'h01;
    emergencyAction <= 12'h4E4;
    overloadAction <= 12'h555;
    forceEnable <= 6'h3F;
    forceValue <= 6'h3F;
    forceHiZ <= 6'h01;
    wr(`MPPS_OFS_CFG, 32'h5A000050);
    check({pwmOut, pwmOutEn}, 12'hFBE);
    comparatorOutput <= 5'h02;
    idle(8);
    check({pwmOut, pwmOutEn}, 12'hCBE);
    check(overloadActive, 3'h2);
    emergencyPin <= 1'b1;
    idle(2);
    check(emergencyActive, 1'b0);
    idle(2);
    check({emergencyActive, pwmOut, pwmOutEn}, 13'h112E);
    idle(2);
    rdchk(`MPPS_OFS_STAT, 32'h3AA);
    check(protIrq, 1'b1);
    emergencyPin <= 1'b0;
    comparatorOutput <= 5'h00;
    idle(8);
    rdchk(`MPPS_OFS_STAT, 32'h2A0);
    wr(`MPPS_OFS_STAT, 32'h00000000);
    rdchk(`MPPS_OFS_STAT, 32'h2A0);
    wr(`MPPS_OFS_STAT, 32'h5A0000A0);
    rdchk(`MPPS_OFS_STAT, 32'h0A0);
    wr(`MPPS_OFS_STAT, 32'h5A000000);
    rdchk(`MPPS_OFS_STAT, 32'h0);
    check(protIrq, 1'b0);
  endtask
  // Comparator emergency path and channel pins; a held event beats a clear
  task automatic t_paths;
    comparatorEmergencyEnable <= 5'h10;
    wr(`MPPS_OFS_CFG, 32'h5A000085);
    comparatorOutput <= 5'h08;
    faultPin <= 3'h7;
    idle(8);
    check({emergencyActive, overloadActive}, 4'h5);
    comparatorOutput <= 5'h10;
    idle(8);
    rdchk(`MPPS_OFS_STAT, 32'h3DD);
    wr(`MPPS_OFS_STAT, 32'h5A000000);
    rdchk(`MPPS_OFS_STAT, 32'h3DD);
    comparatorOutput <= 5'h00;
    faultPin <= 3'h0;
    idle(8);
    wr(`MPPS_OFS_STAT, 32'h5A000000);
    wr(`MPPS_OFS_CFG, 32'h5A000000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Compare: counts pulses over two counter periods, checks what they carry
  task automatic t_cmp(input mpps_word_t cw, input logic [2:0] sel, input logic [3:0] irqs,
                       input logic [3:0] trgs);
    logic [3:0] ni, nt;
    ni = 4'h0;
    nt = 4'h0;
    wr(`MPPS_OFS_CMP0, cw);
    repeat (64) begin
      @(posedge core_clk);
      if (cmpIrq === 1'b1) ni++;
      if (adcStart === 1'b1) begin
        nt++;
        check({counterDir, pwmCounterValue}, {cw[16], cw[15:0] + 16'h0001});
        check({adcEocIrqEnable, adcInput}, {cw[25], sel});
      end
    end
    check({ni, nt}, {irqs, trgs});
  endtask
  // Shadow write waits for the update point; bypass loads at once
  task automatic t_shadow;
    logic [3:0] n;
    wr(`MPPS_OFS_CMP0, 32'h0080FFFF);
    run <= 1'b0;
    idle(2);
    w = {8'h80, 7'h00, counterDir, pwmCounterValue};
    wr(`MPPS_OFS_CMP0, w);
    repeat (6) begin
      @(posedge core_clk);
      check(cmpIrq, 1'b0);
    end
    // Resume: shadow loads at the zero point, the frozen state returns 32 cycles on
    shadowUpdatePoint <= 1'b1;
    run <= 1'b1;
    n = 4'h0;
    repeat (40) begin
      @(posedge core_clk);
      if (cmpIrq === 1'b1) n++;
    end
    check(n, 4'h1);
    run <= 1'b0;
    idle(2);
    w = {8'h80, 7'h00, counterDir, pwmCounterValue};
    wr(`MPPS_OFS_CMP0, w | 32'h00800000);
    n = 4'h0;
    repeat (6) begin
      @(posedge core_clk);
      if (cmpIrq === 1'b1) n++;
    end
    check(n, 4'h1);
    run <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test;
  end
  initial begin
    err_count = 0;
    compares = 0;
    {rst_n, regWrite, regRead, emergencyPin, shadowUpdatePoint, run} = 6'h00;
    {regAddr, regWdata, faultPin, comparatorOutput, comparatorEmergencyEnable} = 53'h0;
    {faultFilterTimeUnit, emergencyAction, overloadAction} = 32'h0;
    {forceEnable, forceHiZ, forceValue, pwmLevel} = 24'h0;
    idle(2);
    rst_n <= 1'b1;
    @(posedge core_clk);
    run <= 1'b1;
    t_regs;
    t_filter;
    t_prot;
    t_paths;
    t_cmp(32'h9B800005, 3'h4, 4'h2, 4'h2);
    for (int i = 0; i < 8; i++) begin
      w = 32'h01800007 | (32'(i) << 26) | (32'(i % 2) << 16);
      t_cmp(w, (i > 4) ? 3'h4 : 3'(i), 4'h0, 4'h2);
    end
    t_shadow;
    stop_test;
  end
endmodule
`default_nettype wire
